// ### rtl/lnb_params.svh
`ifndef LNB_PARAMS_SVH
`define LNB_PARAMS_SVH

// Fixed upper five bits of the seven-bit bus address.
`define LNB_ADDR_HI 5'h02

// Write view of the section system register.
`define LNB_BIT_LIMIT 7
`define LNB_BIT_TTX 6
`define LNB_BIT_TEN 5
`define LNB_BIT_LLC 4
`define LNB_BIT_VOLT_SELECT 3
`define LNB_BIT_EN 2
`define LNB_BIT_TEST_HI 1
`define LNB_BIT_TEST_LO 0

// Read view of the section system register.
`define LNB_RD_LLC 4
`define LNB_RD_VOLT_SELECT 3
`define LNB_RD_EN 2
`define LNB_RD_OTF 1
`define LNB_RD_OLF 0

`define LNB_SR_RESET 8'h00
`define LNB_SECTIONS 2

// Tone timing at the system clock rate.
`define LNB_CLK_HZ 40000000
`define LNB_TONE_HZ 22000
`define LNB_TONE_HALF (`LNB_CLK_HZ / (2 * `LNB_TONE_HZ))

`endif

// ### rtl/lnb_pkg.sv
`include "lnb_params.svh"

package lnb_pkg;

   typedef enum logic [7:0] {
      LNB_IDLE     = 8'h01,
      LNB_ADDR     = 8'h02,
      LNB_ADDR_ACK = 8'h04,
      LNB_WR_DATA  = 8'h08,
      LNB_WR_ACK   = 8'h10,
      LNB_RD_DATA  = 8'h20,
      LNB_RD_ACK   = 8'h40,
      LNB_IGNORE   = 8'h80
   } lnb_bus_state_t;

   // Controls that one section hands to its regulator and tone stage.
   typedef struct packed {
      logic power_en;
      logic [1:0] level_req;
      logic limit_static;
      logic tone_stage_en;
      logic tone_out;
      logic ext_mod_en;
   } lnb_sect_out_t;

   // Protection flags reported by one section.
   typedef struct packed {
      logic overheat_flag;
      logic overload_flag;
   } lnb_sect_stat_t;

   typedef struct packed {
      lnb_bus_state_t st;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic rw;
      logic sec;
      logic ack_ok;
      logic sda_oe;
      logic scl_d;
      logic sda_d;
      logic [7:0] wr_byte;
      logic wr_sec;
      logic wr_tgl;
      logic snap_seen;
      logic [1:0][7:0] snap;
   } lnb_link_state_t;

   typedef struct packed {
      logic [1:0][7:0] ctrl;
      logic wr_seen;
      logic [1:0][7:0] snap;
      logic snap_tgl;
      logic [15:0] tone_cnt;
      logic tone_sq;
      lnb_sect_out_t [1:0] outs;
   } lnb_sys_state_t;

endpackage : lnb_pkg

// ### rtl/lnb_sync3.sv
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; a bit changes once stages two and three agree.
module lnb_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= i_d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
      end
   end

   assign o_q = q_r;

endmodule : lnb_sync3

`default_nettype wire

// ### rtl/lnb_section_ctl.sv
// Summary of operation
// - Data line changes only while clock is low; sampled on clock rise.
// - Start is data falling with clock high; stop is data rising.
// - Bytes are eight bits, MSB first, each followed by an ack slot.
// - Addressed slave pulls data low for the whole ack clock pulse.
// - No acknowledge at all while undervoltage lockout is active.
// - First byte is the address; its LSB set means read.
// - Address is 00010, then a bit set per section by strap, then the section select bit.
// - Write transaction is start, address, one data byte, stop.
// - One interface serves both sections; address picks the register.
// - A write stores the whole data byte into the addressed register.
// - Write bits: limit, tone transmit, always-on, drop comp, volt, power, tests.
// - Read bits: three zeros, drop comp, volt, power, overheat, overload.
// - Reset clears every system register bit, powering blocks down.
// - Volt select and drop comp form a two-bit output level request.
// - Tone transmit with always-on clear gates the tone by the gate input.
// - Tone transmit with always-on set outputs the tone continuously.
// - Tone transmit clear disables the tone and enables external modulation.
// - With power on, tone stage follows tone transmit.
// - Limit style bit clear is pulsed limiting, set is static.
// - Overheat and overload flags read one while their protection acts.
// - Read sends the byte MSB first; host ack asks for another byte.
// - Under lockout commands are ignored and registers held at zero.
`timescale 1ns/10ps
`default_nettype none
`include "lnb_params.svh"

module lnb_section_ctl #(
   parameter int TONE_HALF = `LNB_TONE_HALF
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic [1:0] i_addr_strap,
   input wire logic i_undervoltage_lockout,
   input wire logic [1:0] i_tone_gate_in,
   input wire lnb_pkg::lnb_sect_stat_t [1:0] i_stat,
   output lnb_pkg::lnb_sect_out_t [1:0] o_sect
);

   lnb_pkg::lnb_link_state_t ls_r;
   lnb_pkg::lnb_link_state_t ls_nxt;
   lnb_pkg::lnb_sys_state_t ss_r;
   lnb_pkg::lnb_sys_state_t ss_nxt;

   // Link-domain reset follows the system reset through a synchroniser.
   logic link_rst;
   lnb_sync3 #(
      .W(1),
      .RST_VAL(1'b1)
   ) u_link_rst (
      .i_clk(i_link_clk),
      .i_rst(1'b0),
      .i_d(i_sys_rst),
      .o_q(link_rst)
   );

   logic scl;
   logic sda;
   logic uvlo_l;
   logic snap_tgl_l;
   logic [1:0] strap;
   lnb_sync3 #(
      .W(6),
      .RST_VAL(6'h03)
   ) u_link_sync (
      .i_clk(i_link_clk),
      .i_rst(link_rst),
      .i_d({i_addr_strap, ss_r.snap_tgl, i_undervoltage_lockout, i_scl,
         i_sda}),
      .o_q({strap, snap_tgl_l, uvlo_l, scl, sda})
   );

   logic uvlo_s;
   logic wr_tgl_s;
   logic snap_ack_s;
   logic [1:0] gate_s;
   logic [1:0] otf_s;
   logic [1:0] olf_s;
   lnb_sync3 #(
      .W(9),
      .RST_VAL(9'h000)
   ) u_sys_sync (
      .i_clk(i_clk),
      .i_rst(i_sys_rst),
      .i_d({i_undervoltage_lockout, ls_r.wr_tgl, ls_r.snap_seen,
         i_tone_gate_in, i_stat[1].overheat_flag,
         i_stat[0].overheat_flag, i_stat[1].overload_flag,
         i_stat[0].overload_flag}),
      .o_q({uvlo_s, wr_tgl_s, snap_ack_s, gate_s, otf_s, olf_s})
   );

   // Link side: bus slave running on the oversampling link clock.
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic addr_match;
   logic [7:0] rd_byte;

   assign scl_rise = scl & ~ls_r.scl_d;
   assign scl_fall = ~scl & ls_r.scl_d;
   assign start_det = scl & ls_r.scl_d & ls_r.sda_d & ~sda;
   assign stop_det = scl & ls_r.scl_d & ~ls_r.sda_d & sda;
   // Bit one picks the section and bit two must equal that section's strap.
   assign addr_match = (ls_r.shreg[7:3] == `LNB_ADDR_HI) &&
      (ls_r.shreg[2] == strap[ls_r.shreg[1]]);
   assign rd_byte = ls_r.snap[ls_r.sec];

   always_comb begin
      ls_nxt = ls_r;
      ls_nxt.scl_d = scl;
      ls_nxt.sda_d = sda;
      if (snap_tgl_l != ls_r.snap_seen) begin
         ls_nxt.snap = ss_r.snap;
         ls_nxt.snap_seen = snap_tgl_l;
      end
      if (stop_det) begin
         ls_nxt.st = lnb_pkg::LNB_IDLE;
         ls_nxt.sda_oe = 1'b0;
      end else if (start_det) begin
         ls_nxt.st = lnb_pkg::LNB_ADDR;
         ls_nxt.cnt = 4'h0;
         ls_nxt.sda_oe = 1'b0;
      end else begin
         unique case (ls_r.st)
            lnb_pkg::LNB_IDLE, lnb_pkg::LNB_IGNORE: begin
               ls_nxt.sda_oe = 1'b0;
            end
            lnb_pkg::LNB_ADDR: begin
               if (scl_rise) begin
                  ls_nxt.shreg = {ls_r.shreg[6:0], sda};
                  ls_nxt.cnt = ls_r.cnt + 4'h1;
               end else if (scl_fall && ls_r.cnt == 4'h8) begin
                  ls_nxt.sec = ls_r.shreg[1];
                  ls_nxt.rw = ls_r.shreg[0];
                  if (addr_match && !uvlo_l) begin
                     ls_nxt.st = lnb_pkg::LNB_ADDR_ACK;
                     ls_nxt.sda_oe = 1'b1;
                  end else begin
                     ls_nxt.st = lnb_pkg::LNB_IGNORE;
                  end
               end
            end
            lnb_pkg::LNB_ADDR_ACK: begin
               if (scl_fall) begin
                  ls_nxt.cnt = 4'h0;
                  if (ls_r.rw) begin
                     ls_nxt.shreg = rd_byte;
                     ls_nxt.sda_oe = ~rd_byte[7];
                     ls_nxt.st = lnb_pkg::LNB_RD_DATA;
                  end else begin
                     ls_nxt.sda_oe = 1'b0;
                     ls_nxt.st = lnb_pkg::LNB_WR_DATA;
                  end
               end
            end
            lnb_pkg::LNB_WR_DATA: begin
               if (scl_rise) begin
                  ls_nxt.shreg = {ls_r.shreg[6:0], sda};
                  ls_nxt.cnt = ls_r.cnt + 4'h1;
               end else if (scl_fall && ls_r.cnt == 4'h8) begin
                  if (!uvlo_l) begin
                     ls_nxt.wr_byte = ls_r.shreg;
                     ls_nxt.wr_sec = ls_r.sec;
                     ls_nxt.wr_tgl = ~ls_r.wr_tgl;
                     ls_nxt.sda_oe = 1'b1;
                     ls_nxt.st = lnb_pkg::LNB_WR_ACK;
                  end else begin
                     ls_nxt.st = lnb_pkg::LNB_IGNORE;
                  end
               end
            end
            lnb_pkg::LNB_WR_ACK: begin
               // Only one data byte per transaction; the rest is ignored.
               if (scl_fall) begin
                  ls_nxt.sda_oe = 1'b0;
                  ls_nxt.st = lnb_pkg::LNB_IGNORE;
               end
            end
            lnb_pkg::LNB_RD_DATA: begin
               if (scl_rise) begin
                  ls_nxt.cnt = ls_r.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (ls_r.cnt == 4'h8) begin
                     ls_nxt.sda_oe = 1'b0;
                     ls_nxt.st = lnb_pkg::LNB_RD_ACK;
                  end else begin
                     ls_nxt.shreg = {ls_r.shreg[6:0], 1'b0};
                     ls_nxt.sda_oe = ~ls_r.shreg[6];
                  end
               end
            end
            lnb_pkg::LNB_RD_ACK: begin
               if (scl_rise) begin
                  ls_nxt.ack_ok = ~sda;
               end else if (scl_fall) begin
                  if (ls_r.ack_ok) begin
                     ls_nxt.cnt = 4'h0;
                     ls_nxt.shreg = rd_byte;
                     ls_nxt.sda_oe = ~rd_byte[7];
                     ls_nxt.st = lnb_pkg::LNB_RD_DATA;
                  end else begin
                     ls_nxt.st = lnb_pkg::LNB_IGNORE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_link_clk) begin
      if (link_rst) begin
         ls_r <= '{st: lnb_pkg::LNB_IDLE, cnt: 4'h0, shreg: 8'h00,
            rw: 1'b0, sec: 1'b0, ack_ok: 1'b0, sda_oe: 1'b0, scl_d: 1'b1,
            sda_d: 1'b1, wr_byte: 8'h00, wr_sec: 1'b0, wr_tgl: 1'b0,
            snap_seen: 1'b0, snap: 16'h0000};
      end else begin
         ls_r <= ls_nxt;
      end
   end

   assign o_sda_o = 1'b0;
   assign o_sda_oe = ls_r.sda_oe;

   // System side: registers, read snapshot and per-section outputs.
   logic [1:0][7:0] rd_view;
   lnb_pkg::lnb_sect_out_t [1:0] out_view;
   logic tone_wrap;

   assign tone_wrap = (ss_r.tone_cnt == 16'(TONE_HALF - 1));

   genvar g;
   generate
      for (g = 0; g < `LNB_SECTIONS; g = g + 1) begin : g_sect
         logic [7:0] c;
         logic pwr;
         logic tone_transmit_en;
         assign c = ss_r.ctrl[g];
         assign pwr = c[`LNB_BIT_EN];
         assign tone_transmit_en = c[`LNB_BIT_TTX];
         // The top three bits of the read view are not reported and always read zero.
         assign rd_view[g] = {3'h0, c[`LNB_BIT_LLC], c[`LNB_BIT_VOLT_SELECT],
            c[`LNB_BIT_EN], otf_s[g], olf_s[g]};
         assign out_view[g].power_en = pwr;
         assign out_view[g].level_req = pwr ?
            {c[`LNB_BIT_VOLT_SELECT], c[`LNB_BIT_LLC]} : 2'h0;
         assign out_view[g].limit_static = pwr & c[`LNB_BIT_LIMIT];
         assign out_view[g].tone_stage_en = pwr & tone_transmit_en;
         assign out_view[g].tone_out = pwr & tone_transmit_en & ss_r.tone_sq &
            (c[`LNB_BIT_TEN] | gate_s[g]);
         assign out_view[g].ext_mod_en = pwr & ~tone_transmit_en;
      end
   endgenerate

   always_comb begin
      ss_nxt = ss_r;
      ss_nxt.wr_seen = wr_tgl_s;
      if (wr_tgl_s != ss_r.wr_seen && !uvlo_s) begin
         ss_nxt.ctrl[ls_r.wr_sec] = ls_r.wr_byte;
      end
      if (uvlo_s) begin
         ss_nxt.ctrl = {`LNB_SR_RESET, `LNB_SR_RESET};
      end
      // The view is recaptured only after the link side has taken the last.
      if (snap_ack_s == ss_r.snap_tgl) begin
         ss_nxt.snap = rd_view;
         ss_nxt.snap_tgl = ~ss_r.snap_tgl;
      end
      if (tone_wrap) begin
         ss_nxt.tone_cnt = 16'h0000;
         ss_nxt.tone_sq = ~ss_r.tone_sq;
      end else begin
         ss_nxt.tone_cnt = ss_r.tone_cnt + 16'h0001;
      end
      ss_nxt.outs = out_view;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ss_r <= '0;
      end else begin
         ss_r <= ss_nxt;
      end
   end

   assign o_sect = ss_r.outs;

endmodule : lnb_section_ctl

`default_nettype wire

// ### verif/lnb_section_ctl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module lnb_section_ctl_chk #(
   parameter int TONE_HALF = 4
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   input wire logic i_undervoltage_lockout,
   input wire lnb_pkg::lnb_sect_out_t [1:0] o_sect
);
   property p_gate(int s);
      @(posedge i_clk) disable iff (i_sys_rst)
      !o_sect[s].power_en |-> o_sect[s] == '0;
   endproperty
   chk_gate_sect_a: assert property (p_gate(0))
      else $error("section a active while unpowered");
   chk_gate_sect_b: assert property (p_gate(1))
      else $error("section b active while unpowered");
   // While section 0 is powered, exactly one of its tone stage and external modulation path runs.
   chk_tone_mode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_sect[0].power_en |-> o_sect[0].tone_stage_en != o_sect[0].ext_mod_en)
      else $error("tone stage and modulation path clash");
   chk_tone_rise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_sect[0].tone_out) |-> o_sect[0].tone_stage_en)
      else $error("tone edge with tone stage off");
   chk_reset_clear: assert property (@(posedge i_clk)
      i_sys_rst [*3] |-> o_sect == '0)
      else $error("controls not cleared by reset");
   chk_lockout_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_undervoltage_lockout [*8] |-> o_sect == '0)
      else $error("controls active under lockout");
   chk_lockout_noack: assert property (@(posedge i_link_clk)
      disable iff (i_sys_rst) i_undervoltage_lockout [*8] |-> !o_sda_oe)
      else $error("data line pulled under lockout");
   chk_drive_low: assert property (@(posedge i_link_clk)
      o_sda_oe |-> !o_sda_o)
      else $error("data line driven high");
   chk_oe_scl_low: assert property (@(posedge i_link_clk)
      disable iff (i_sys_rst) $changed(o_sda_oe) |-> !i_scl)
      else $error("data line moved with bus clock high");
   cov_power: cover property (@(posedge i_clk) $rose(o_sect[0].power_en));
   cov_tone: cover property (@(posedge i_clk) $rose(o_sect[0].tone_out));
   cov_ack: cover property (@(posedge i_link_clk) $rose(o_sda_oe));
endmodule : lnb_section_ctl_chk
bind lnb_section_ctl lnb_section_ctl_chk #(.TONE_HALF(TONE_HALF)) i_chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
   .i_scl(i_scl), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
   .i_undervoltage_lockout(i_undervoltage_lockout), .o_sect(o_sect));
`default_nettype wire

// ### verif/lnb_host.sv
`timescale 1ns/10ps
`default_nettype none
module lnb_host (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   logic [7:0] res;
   event got;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic qp();
      repeat (25) @(posedge i_clk);
   endtask : qp
   // Data moves mid low phase so it never races the clock edge.
   task automatic slot(input logic b, output logic r);
      qp();
      o_sda_low <= ~b;
      qp();
      o_scl <= 1'b1;
      qp();
      qp();
      r = i_sda;
      o_scl <= 1'b0;
   endtask : slot
   task automatic bytex(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
      slot(ak, a);
      res = d[0] ? q : {7'h00, a};
   endtask : bytex
   task automatic xfer(input logic [7:0] a8, input logic [7:0] d, input int n);
      logic [7:0] q;
      logic a;
      o_sda_low <= 1'b1;
      qp();
      o_scl <= 1'b0;
      bytex(a8, 1'b1, q, a);
      res = {7'h00, a};
      -> got;
      if (!a8[0]) begin
         bytex(d, 1'b1, q, a);
         res = {7'h00, a};
         -> got;
      end
      for (int i = 0; i < n; i++) begin
         bytex(8'hFF, i == n - 1, q, a);
         -> got;
      end
      qp();
      o_sda_low <= 1'b1;
      qp();
      o_scl <= 1'b1;
      qp();
      o_sda_low <= 1'b0;
      qp();
   endtask : xfer
endmodule : lnb_host
`default_nettype wire

// ### verif/lnb_section_ctl_test.sv
`timescale 1ns/10ps
`default_nettype none
module lnb_section_ctl_test;
   logic i_clk, i_link_clk, i_sys_rst, scl, sda_low, sda, o_sda_o, o_sda_oe;
   logic undervoltage_lockout;
   logic [1:0] strap, gate;
   logic [3:0] stat;
   lnb_pkg::lnb_sect_out_t [1:0] o_sect;
   logic [7:0] exp_q [$];
   logic [7:0] v [2];
   int n_fail, checked;
   assign sda = !(sda_low || (o_sda_oe && !o_sda_o));
   lnb_section_ctl #(.TONE_HALF(4)) i_dut (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .i_scl(scl),
      .i_sda(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
      .i_addr_strap(strap), .i_undervoltage_lockout(undervoltage_lockout),
      .i_tone_gate_in(gate), .i_stat(stat), .o_sect(o_sect));
   lnb_host i_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));
   always #12.5 i_clk = ~i_clk;
   initial begin
      i_clk = 1'b0;
      i_link_clk = 1'b0;
      #3.1;
      forever #62.5 i_link_clk = ~i_link_clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   function automatic logic [6:0] so(input logic [7:0] d);
      so = d[2] ? {1'b1, d[3], d[4], d[7], d[6], 1'b0, ~d[6]} : 7'h00;
   endfunction : so
   function automatic logic [7:0] ad(input int s, input logic rw);
      ad = {5'h02, strap[s], s[0], rw};
   endfunction : ad
   function automatic logic [7:0] rexp(input int s);
      rexp = (v[s] & 8'h1C) | {6'h00, stat[2*s +: 2]};
   endfunction : rexp
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
      exp_q.push_back({7'h00, ~ok});
      exp_q.push_back({7'h00, ~ok});
      i_host.xfer(a, d, 0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ok);
      exp_q.push_back({7'h00, ~ok});
      exp_q.push_back(ok ? e : 8'hFF);
      exp_q.push_back(ok ? e : 8'hFF);
      i_host.xfer(a, 8'hFF, 2);
   endtask : rd
   task automatic cmp_out();
      @(negedge i_clk);
      check({2'b00, o_sect & 14'h3EFD}, {2'b00, so(v[1]), so(v[0])});
   endtask : cmp_out
   // Cycles between two tone edges; 40 means the tone stood still.
   task automatic gap(output logic [15:0] n);
      logic t;
      n = 16'h0000;
      @(negedge i_clk);
      t = o_sect[0].tone_out;
      for (int i = 0; i < 40 && o_sect[0].tone_out === t; i++) @(negedge i_clk);
      t = o_sect[0].tone_out;
      while (n < 16'd40 && o_sect[0].tone_out === t) begin
         @(negedge i_clk);
         n++;
      end
   endtask : gap
   always @(i_host.got) check({8'h00, i_host.res}, {8'h00, exp_q.pop_front()});
   initial begin
      repeat (80000) @(posedge i_clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      logic [7:0] d;
      logic [15:0] n;
      i_sys_rst = 1'b1;
      undervoltage_lockout = 1'b0;
      gate = 2'b00;
      v[0] = 8'h00;
      v[1] = 8'h00;
      void'($urandom(32'h3017));
      strap = 2'($urandom);
      stat = 4'($urandom);
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (60) @(posedge i_clk);
      cmp_out();
      for (int s = 0; s < 2; s++) rd(ad(s, 1'b1), rexp(s), 1'b1);
      for (int k = 0; k < 6; k++) begin
         stat <= 4'($urandom);
         d = 8'($urandom) & 8'hFC;
         wr(ad(k % 2, 1'b0), d, 1'b1);
         v[k % 2] = d;
         cmp_out();
         rd(ad(k % 2, 1'b1), rexp(k % 2), 1'b1);
      end
      wr({5'h02, ~strap[0], 2'b00}, 8'h04, 1'b0);
      wr(8'h60, 8'h04, 1'b0);
      cmp_out();
      undervoltage_lockout <= 1'b1;
      repeat (20) @(posedge i_clk);
      v[0] = 8'h00;
      v[1] = 8'h00;
      cmp_out();
      wr(ad(0, 1'b0), 8'h84, 1'b0);
      rd(ad(1, 1'b1), 8'hFF, 1'b0);
      undervoltage_lockout <= 1'b0;
      repeat (60) @(posedge i_clk);
      rd(ad(0, 1'b1), rexp(0), 1'b1);
      wr(ad(0, 1'b0), 8'h64, 1'b1);
      v[0] = 8'h64;
      gap(n);
      check(n, 16'd4);
      wr(ad(0, 1'b0), 8'h44, 1'b1);
      v[0] = 8'h44;
      gap(n);
      check(n, 16'd40);
      gate <= 2'b01;
      repeat (10) @(posedge i_clk);
      gap(n);
      check(n, 16'd4);
      wr(ad(0, 1'b0), 8'h1C, 1'b1);
      v[0] = 8'h1C;
      cmp_out();
      gap(n);
      check(n, 16'd40);
      check({8'h00, 8'(exp_q.size())}, 16'h0000);
      print_verdict();
   end
endmodule : lnb_section_ctl_test
`default_nettype wire
